/* src/qmgp_pkg.sv */
// Constants shared by the quad-mode GPIO port block.
package qmgp_pkg;

    // ****************************************************************
    // Register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] GLOBAL_CFG_ADDR = 8'h80;
    localparam logic [4:0] REG_DATA        = 5'h00;
    localparam logic [4:0] REG_LATCH       = 5'h04;
    localparam logic [4:0] REG_MODE_LO     = 5'h08;
    localparam logic [4:0] REG_MODE_HI     = 5'h0c;
    localparam logic [4:0] REG_ITYPE       = 5'h10;
    localparam logic [4:0] REG_SLEW        = 5'h14;
    localparam logic [4:0] REG_BITOP       = 5'h18;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CFG_PULLUP_BIT = 7;
    localparam int CFG_RPD_BIT    = 0;
    localparam int CFG_DBG_BIT    = 1;
    localparam int BITOP_IDX_LSB  = 0;
    localparam int BITOP_OP_LSB   = 4;
    localparam int BITOP_CARRY    = 8;

    // Bit operation codes.
    localparam logic [1:0] OP_SET   = 2'h1;
    localparam logic [1:0] OP_CLEAR = 2'h2;
    localparam logic [1:0] OP_MOVE  = 2'h3;

    // ****************************************************************
    // Pin population and reset values, port 3 in the top byte
    // ****************************************************************
    localparam logic [31:0] PIN_MASK       = 32'h0101_ffff;
    localparam logic [31:0] WRITE_MASK     = 32'h0100_ffff;
    localparam logic [31:0] LATCH_RST      = 32'h0100_ffff;
    localparam logic [31:0] MODE_LO_RST    = 32'h0100_ffff;
    localparam logic [31:0] MODE_HI_RST    = 32'h0000_0000;
    localparam logic [31:0] ITYPE_RST      = 32'h0000_0000;
    localparam logic [31:0] SLEW_RST       = 32'h0000_0000;
    localparam logic [31:0] RESET_PIN_BIT  = 32'h0001_0000;
    localparam logic [31:0] DEBUG_PIN_MASK = 32'h0000_c000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int         DEBUG_HOLD_TICKS = 600;
    localparam logic [9:0] DEBUG_HOLD_CNT   = 10'(DEBUG_HOLD_TICKS);

endpackage

/* src/qmgp_port.sv */
// Quad-mode GPIO port block with an Avalon-MM register slave.
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps

module qmgp_port (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Boot option and slow oscillator tick
    input  wire logic        i_reset_pin_disable_option,
    input  wire logic        i_low_speed_internal_osc_tick,
    // Pads, bit 8*port+n
    input  wire logic [31:0] i_pin,
    output logic [31:0]      o_pin_o,
    output logic [31:0]      o_pin_oe,
    output logic [31:0]      o_pu_very_weak,
    output logic [31:0]      o_pu_weak,
    output logic [31:0]      o_pu_strong,
    output logic [31:0]      o_pd_strong,
    output logic [31:0]      o_schmitt_sel,
    output logic [31:0]      o_fast_slew,
    output logic             o_reset_pin_pullup
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [3:0][7:0] latch_q;
    logic [3:0][7:0] latch_prev_q;
    logic [3:0][7:0] mode_lo_q;
    logic [3:0][7:0] mode_hi_q;
    logic [3:0][7:0] itype_q;
    logic [3:0][7:0] slew_q;
    logic [31:0]     pin_s1_q;
    logic [31:0]     pin_s2_q;
    logic [31:0]     strong_tail_q;
    logic            pullup_en_q;
    logic            rpd_q;
    logic [9:0]      dbg_cnt_q;
    logic            ack_q;
    logic [31:0]     rdata_q;

    logic            req;
    logic            wr_go;
    logic            rd_go;
    logic            port_wr;
    logic            wr_latch;
    logic            wr_bitop;
    logic            wr_mode_lo;
    logic            wr_mode_hi;
    logic            wr_itype;
    logic            wr_slew;
    logic            wr_cfg;
    logic            is_global;
    logic [1:0]      sel_port;
    logic [4:0]      sel_reg;
    logic [7:0]      wbyte;
    logic [7:0]      port_wmask;
    logic [7:0]      bitop_byte;
    logic [2:0]      bit_idx;
    logic [1:0]      bit_op;
    logic            dbg_hold;
    logic [31:0]     ml;
    logic [31:0]     mh;
    logic [31:0]     strong_pulse;
    logic [31:0]     latch_flat;
    logic [31:0]     strong_head;
    logic [31:0]     rd_word;

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // Every access takes one wait state: the first cycle decodes and
    // registers read data, the second releases waitrequest.
    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_q;
    assign rd_go             = i_avs_read & ~ack_q;
    assign wr_go             = i_avs_write & ack_q & i_avs_byteenable[0];
    assign o_avs_readdata    = rdata_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    assign is_global  = (i_avs_address == qmgp_pkg::GLOBAL_CFG_ADDR);
    assign sel_port   = i_avs_address[6:5];
    assign sel_reg    = i_avs_address[4:0];
    assign wbyte      = i_avs_writedata[7:0];
    assign port_wmask = qmgp_pkg::WRITE_MASK[sel_port*8 +: 8];
    assign bit_idx    = i_avs_writedata[qmgp_pkg::BITOP_IDX_LSB +: 3];
    assign bit_op     = i_avs_writedata[qmgp_pkg::BITOP_OP_LSB +: 2];

    // ****************************************************************
    // Register write strobes
    // ****************************************************************
    // Writes land on the edge that ends the second cycle, the same edge at
    // which the master sees waitrequest low, never a cycle earlier.
    assign port_wr    = wr_go & ~i_avs_address[7];
    assign wr_latch   = port_wr & (sel_reg == qmgp_pkg::REG_DATA || sel_reg == qmgp_pkg::REG_LATCH);
    assign wr_bitop   = port_wr & (sel_reg == qmgp_pkg::REG_BITOP);
    assign wr_mode_lo = port_wr & (sel_reg == qmgp_pkg::REG_MODE_LO);
    assign wr_mode_hi = port_wr & (sel_reg == qmgp_pkg::REG_MODE_HI);
    assign wr_itype   = port_wr & (sel_reg == qmgp_pkg::REG_ITYPE);
    assign wr_slew    = port_wr & (sel_reg == qmgp_pkg::REG_SLEW);
    assign wr_cfg     = wr_go & is_global;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_global) begin
            rd_word[qmgp_pkg::CFG_PULLUP_BIT] = pullup_en_q;
            rd_word[qmgp_pkg::CFG_RPD_BIT]    = rpd_q;
            rd_word[qmgp_pkg::CFG_DBG_BIT]    = dbg_hold;
        end else if (i_avs_address[7]) begin
            rd_word = 32'h0000_0000;
        end else if (sel_reg == qmgp_pkg::REG_DATA) begin
            // Pins, not the latch; the shared pin reads 0 as reset input.
            rd_word[7:0] = pin_s2_q[sel_port*8 +: 8] & qmgp_pkg::PIN_MASK[sel_port*8 +: 8];
            if (sel_port == 2'd2 && rpd_q) begin
                rd_word[0] = 1'b0;
            end
        end else if (sel_reg == qmgp_pkg::REG_LATCH) begin
            rd_word[7:0] = latch_q[sel_port];
        end else if (sel_reg == qmgp_pkg::REG_MODE_LO) begin
            rd_word[7:0] = mode_lo_q[sel_port];
        end else if (sel_reg == qmgp_pkg::REG_MODE_HI) begin
            rd_word[7:0] = mode_hi_q[sel_port];
        end else if (sel_reg == qmgp_pkg::REG_ITYPE) begin
            rd_word[7:0] = itype_q[sel_port];
        end else if (sel_reg == qmgp_pkg::REG_SLEW) begin
            rd_word[7:0] = slew_q[sel_port];
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    // Read data are caught on the first edge of the access and then held,
    // so the value already stands when the master samples it.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            rdata_q <= rd_word;
        end
    end

    // ****************************************************************
    // Output latches
    // ****************************************************************
    // A bit operation reads the whole latch, alters one bit and writes
    // the full byte back, so neighbouring pins keep their latch value
    // even if something outside holds them low.
    always_comb begin
        bitop_byte = latch_q[sel_port];
        if (bit_op == qmgp_pkg::OP_SET) begin
            bitop_byte[bit_idx] = 1'b1;
        end else if (bit_op == qmgp_pkg::OP_CLEAR) begin
            bitop_byte[bit_idx] = 1'b0;
        end else if (bit_op == qmgp_pkg::OP_MOVE) begin
            bitop_byte[bit_idx] = i_avs_writedata[qmgp_pkg::BITOP_CARRY];
        end else begin
            bitop_byte = latch_q[sel_port];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            latch_q <= qmgp_pkg::LATCH_RST;
        end else if (wr_latch) begin
            latch_q[sel_port] <= wbyte & port_wmask;
        end else if (wr_bitop) begin
            latch_q[sel_port] <= bitop_byte & port_wmask;
        end
    end

    // Last cycle's latch, kept so that a 0-to-1 step can be seen.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            latch_prev_q <= qmgp_pkg::LATCH_RST;
        end else begin
            latch_prev_q <= latch_q;
        end
    end

    // ****************************************************************
    // Mode, input type and slew registers
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mode_lo_q <= qmgp_pkg::MODE_LO_RST;
            mode_hi_q <= qmgp_pkg::MODE_HI_RST;
        end else if (wr_mode_lo) begin
            mode_lo_q[sel_port] <= wbyte & port_wmask;
        end else if (wr_mode_hi) begin
            mode_hi_q[sel_port] <= wbyte & port_wmask;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            itype_q <= qmgp_pkg::ITYPE_RST;
            slew_q  <= qmgp_pkg::SLEW_RST;
        end else if (wr_itype) begin
            itype_q[sel_port] <= wbyte & port_wmask;
        end else if (wr_slew) begin
            slew_q[sel_port] <= wbyte & port_wmask;
        end
    end

    // ****************************************************************
    // Shared reset pin settings
    // ****************************************************************
    // The boot option is a strap: it is caught while reset is held so a
    // later change on the input cannot alter the pin's role.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rpd_q <= i_reset_pin_disable_option;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pullup_en_q <= 1'b0;
        end else if (wr_cfg) begin
            pullup_en_q <= wbyte[qmgp_pkg::CFG_PULLUP_BIT];
        end
    end

    assign o_reset_pin_pullup = rpd_q | pullup_en_q;

    // ****************************************************************
    // Debug pin hold after reset
    // ****************************************************************
    // The hold counts slow-oscillator ticks, not clock cycles, so its
    // length does not depend on the CPU clock rate.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            dbg_cnt_q <= 10'h000;
        end else if (dbg_hold && i_low_speed_internal_osc_tick) begin
            dbg_cnt_q <= dbg_cnt_q + 10'h001;
        end
    end

    assign dbg_hold = (dbg_cnt_q != qmgp_pkg::DEBUG_HOLD_CNT);

    // ****************************************************************
    // Pin synchronizer
    // ****************************************************************
    // Pads change with no regard to the clock; only the second flop is
    // read, so the first has a full cycle to settle.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pin_s1_q <= 32'h0000_0000;
            pin_s2_q <= 32'h0000_0000;
        end else begin
            pin_s1_q <= i_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    // The debug pins are forced to quasi while the hold runs, and the
    // shared reset pin is always input-only whatever software writes.
    always_comb begin
        ml = mode_lo_q;
        mh = mode_hi_q;
        if (dbg_hold) begin
            ml = ml & ~qmgp_pkg::DEBUG_PIN_MASK;
            mh = mh & ~qmgp_pkg::DEBUG_PIN_MASK;
        end
        ml = ml | qmgp_pkg::RESET_PIN_BIT;
        mh = mh & ~qmgp_pkg::RESET_PIN_BIT;
    end

    assign latch_flat = dbg_hold ? (latch_q | qmgp_pkg::DEBUG_PIN_MASK) : latch_q;

    // ****************************************************************
    // Strong pull-up pulse
    // ****************************************************************
    // The strong pull-up pulse covers the cycle the latch rises and the
    // one after it: exactly two clocks, then weak pulls hold the pin.
    assign strong_head = latch_q & ~latch_prev_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            strong_tail_q <= 32'h0000_0000;
        end else begin
            strong_tail_q <= strong_head;
        end
    end

    // The pulse is cut short if software clears the latch inside it, so
    // the strong pull-up never fights the pull-down on the same pin.
    assign strong_pulse = (strong_head | strong_tail_q) & latch_flat;

    // ****************************************************************
    // Pad drivers
    // ****************************************************************
    // Each pin's two mode bits select one driver set; unpopulated and
    // input-only pins leave every driver off.
    always_comb begin
        o_pu_very_weak = 32'h0000_0000;
        o_pu_weak      = 32'h0000_0000;
        o_pu_strong    = 32'h0000_0000;
        o_pd_strong    = 32'h0000_0000;
        for (int n = 0; n < 32; n++) begin
            if (qmgp_pkg::PIN_MASK[n]) begin
                case ({ml[n], mh[n]})
                    2'b00: begin
                        o_pu_very_weak[n] = latch_flat[n];
                        o_pu_weak[n]      = pin_s2_q[n];
                        o_pu_strong[n]    = strong_pulse[n];
                        o_pd_strong[n]    = ~latch_flat[n];
                    end
                    2'b01: begin
                        o_pu_strong[n] = latch_flat[n];
                        o_pd_strong[n] = ~latch_flat[n];
                    end
                    2'b11: begin
                        o_pd_strong[n] = ~latch_flat[n];
                    end
                    2'b10: begin
                        o_pd_strong[n] = 1'b0;
                    end
                    default: begin
                        o_pd_strong[n] = 1'b0;
                    end
                endcase
            end
        end
    end

    assign o_pin_o        = o_pu_strong;
    assign o_pin_oe       = o_pu_strong | o_pd_strong;
    assign o_schmitt_sel  = (itype_q & qmgp_pkg::PIN_MASK) | qmgp_pkg::RESET_PIN_BIT;
    assign o_fast_slew    = slew_q & qmgp_pkg::PIN_MASK;

endmodule

/* bench/qmgp_port_chk.sv */
// Assertion checker for the quad-mode GPIO port.
`timescale 1ns/1ps
module qmgp_port_chk (
    // Clock, reset and bus
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // Strap and pads
    input wire logic        i_reset_pin_disable_option,
    input wire logic [31:0] i_pin,
    input wire logic [31:0] o_pin_oe,
    input wire logic [31:0] o_pu_very_weak,
    input wire logic [31:0] o_pu_weak,
    input wire logic [31:0] o_pu_strong,
    input wire logic [31:0] o_pd_strong,
    input wire logic [31:0] o_schmitt_sel,
    input wire logic [31:0] o_fast_slew,
    input wire logic        o_reset_pin_pullup
);
    default clocking dc @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_wait_once:
        assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest held for more than one cycle");
    a_rdata_upper:
        assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_rdata_hold:
        assert property (i_avs_read && !o_avs_waitrequest |=> $stable(o_avs_readdata))
        else $error("read data changed after completion");
    a_weak_sense:
        assert property ((o_pu_weak & ~$past(i_pin, 2)) == 32'h0)
        else $error("weak pull-up on while sensed pin low");
    a_drive_excl:
        assert property ((o_pd_strong & (o_pu_strong | o_pu_very_weak)) == 32'h0)
        else $error("pull-down and pull-up on together");
    a_oe_drive:
        assert property (o_pin_oe == (o_pu_strong | o_pd_strong))
        else $error("output enable does not match drivers");
    a_shared_pin:
        assert property (o_schmitt_sel[16] && !o_pd_strong[16] && !o_pu_strong[16] && !o_pu_weak[16])
        else $error("shared pin not a Schmitt input");
    a_unpop_zero:
        assert property (((o_pu_weak | o_pu_strong | o_pd_strong | o_fast_slew) & ~qmgp_pkg::PIN_MASK) == 32'h0)
        else $error("unpopulated pin driven");
    a_strap_pull:
        assert property (i_reset_pin_disable_option |-> o_reset_pin_pullup)
        else $error("reset pin pull-up off while used as reset");
endmodule

bind qmgp_port qmgp_port_chk qmgp_port_chk_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_reset_pin_disable_option(i_reset_pin_disable_option), .i_pin(i_pin), .o_pin_oe(o_pin_oe),
    .o_pu_very_weak(o_pu_very_weak), .o_pu_weak(o_pu_weak), .o_pu_strong(o_pu_strong),
    .o_pd_strong(o_pd_strong), .o_schmitt_sel(o_schmitt_sel), .o_fast_slew(o_fast_slew),
    .o_reset_pin_pullup(o_reset_pin_pullup));

/* bench/qmgp_board.sv */
// Board model of the circuitry on the port pins.
`timescale 1ns/1ps
module qmgp_board (
    // Drivers from the port
    input  wire logic [31:0] i_pu_strong,
    input  wire logic [31:0] i_pd_strong,
    // External devices
    input  wire logic [31:0] i_ext_en,
    input  wire logic [31:0] i_ext_val,
    // Pad levels
    output logic [31:0]      o_pin
);
    // Board resistors pull every pin high, so a released pin reads 1.
    // An external device overpowers the weak pull-ups but never the strong drivers.
    always_comb begin
        o_pin = ~i_pd_strong & (i_pu_strong | ~i_ext_en | i_ext_val);
    end
endmodule

/* bench/tb_top.sv */
// Self-checking testbench for the quad-mode GPIO port.
`timescale 1ns/1ps
module tb_top;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam logic [4:0] R_DAT = qmgp_pkg::REG_DATA;
    localparam logic [4:0] R_LAT = qmgp_pkg::REG_LATCH;
    localparam logic [4:0] REGS [5] = '{R_LAT, qmgp_pkg::REG_MODE_LO, qmgp_pkg::REG_MODE_HI,
                                        qmgp_pkg::REG_ITYPE, qmgp_pkg::REG_SLEW};
    localparam logic [31:0] RSTS [5] = '{qmgp_pkg::LATCH_RST, qmgp_pkg::MODE_LO_RST, qmgp_pkg::MODE_HI_RST,
                                         qmgp_pkg::ITYPE_RST, qmgp_pkg::SLEW_RST};
    localparam logic [1:0] OPS [4] = '{qmgp_pkg::OP_SET, qmgp_pkg::OP_CLEAR, qmgp_pkg::OP_MOVE, qmgp_pkg::OP_MOVE};
    localparam logic [2:0] IDX [4] = '{3'h7, 3'h0, 3'h4, 3'h7};
    localparam logic       CAR [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    localparam logic [7:0] EXP [4] = '{8'h8f, 8'h8e, 8'h9e, 8'h1e};
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic        opt = 1'b1;
    logic        tick = 1'b0;
    logic [31:0] ext_en = 32'h0;
    logic [31:0] ext_val = 32'h0;
    logic [31:0] i_pin, rdata, oe, pu_vw, pu_w, pu_s, pd_s, schm, slew, pin_o;
    logic        wait_rq, rpu;
    logic [7:0]  rdat;
    int          num_errors = 0;
    int          comparisons = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    qmgp_port qmgp_port_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(4'h1), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
        .i_reset_pin_disable_option(opt), .i_low_speed_internal_osc_tick(tick), .i_pin(i_pin),
        .o_pin_o(pin_o), .o_pin_oe(oe), .o_pu_very_weak(pu_vw), .o_pu_weak(pu_w), .o_pu_strong(pu_s),
        .o_pd_strong(pd_s), .o_schmitt_sel(schm), .o_fast_slew(slew), .o_reset_pin_pullup(rpu));
    qmgp_board qmgp_board_i (.i_pu_strong(pu_s), .i_pd_strong(pd_s), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_pin(i_pin));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        do begin
            @(posedge i_ref_clk);
        end while (wait_rq !== 1'b0);
        if (!wr) chk("rdata_upper", {rdata[31:8], 8'h00}, 32'h0);
        rdat = rdata[7:0];
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    function automatic logic [7:0] ra(input int p, input logic [4:0] r);
        return 8'(p * 32) | {3'h0, r};
    endfunction
    task automatic wreg(input int p, input logic [4:0] r, input logic [7:0] d);
        bus(1'b1, ra(p, r), {24'h0, d});
    endtask
    task automatic rchk(input string n, input int p, input logic [4:0] r, input logic [7:0] e);
        bus(1'b0, ra(p, r), 32'h0);
        chk(n, {24'h0, rdat}, {24'h0, e});
    endtask
    task automatic do_reset(input logic o);
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        opt <= o;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
    endtask
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        do_reset(1'b1);
        @(posedge i_ref_clk);
        #1;
        chk("very_weak", pu_vw, qmgp_pkg::DEBUG_PIN_MASK);
        chk("pull_down", pd_s, 32'h0);
        chk("schmitt", schm, 32'h0001_0000);
        chk("slew", slew, 32'h0);
        rchk("cfg", 4, R_DAT, 8'h03);
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < 5; k++) rchk("reset_val", p, REGS[k], 8'(RSTS[k] >> (8 * p)));
        end
        tick <= 1'b1;
        repeat (qmgp_pkg::DEBUG_HOLD_TICKS + 4) @(posedge i_ref_clk);
        #1;
        chk("very_weak", pu_vw, 32'h0);
        $display("test reset done");
        wreg(0, qmgp_pkg::REG_MODE_LO, 8'hfc);
        wreg(0, qmgp_pkg::REG_MODE_HI, 8'h0a);
        wreg(0, R_DAT, 8'h00);
        #1;
        chk("pull_down", pd_s, 32'h0000_000b);
        chk("oe", oe, 32'h0000_000b);
        chk("very_weak", pu_vw, 32'h0);
        wreg(0, R_DAT, 8'h0f);
        #1;
        chk("strong", pu_s, 32'h0000_0003);
        @(posedge i_ref_clk);
        #1;
        chk("strong", pu_s, 32'h0000_0003);
        @(posedge i_ref_clk);
        #1;
        chk("strong", pu_s, 32'h0000_0002);
        chk("pin_o", pin_o, 32'h0000_0002);
        chk("very_weak", pu_vw, 32'h0000_0001);
        chk("pull_down", pd_s, 32'h0);
        @(posedge i_ref_clk);
        ext_en <= 32'h0000_ff01;
        ext_val <= 32'h0000_5a00;
        #1;
        chk("weak", pu_w, 32'h0000_0001);
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk("weak", pu_w, 32'h0);
        rchk("pins", 0, R_DAT, 8'hfe);
        rchk("pins", 1, R_DAT, 8'h5a);
        rchk("latch", 0, R_LAT, 8'h0f);
        $display("test modes done");
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, ra(0, qmgp_pkg::REG_BITOP), {23'h0, CAR[k], 2'h0, OPS[k], 1'b0, IDX[k]});
            rchk("bitop", 0, R_LAT, EXP[k]);
        end
        wreg(1, qmgp_pkg::REG_ITYPE, 8'ha5);
        wreg(0, qmgp_pkg::REG_SLEW, 8'h3c);
        #1;
        chk("schmitt", schm, 32'h0001_a500);
        chk("slew", slew, 32'h0000_003c);
        $display("test bitops done");
        chk("reset_pullup", {31'h0, rpu}, 32'h1);
        rchk("shared_pin", 2, R_DAT, 8'h00);
        wreg(2, qmgp_pkg::REG_MODE_LO, 8'hff);
        rchk("shared_mode", 2, qmgp_pkg::REG_MODE_LO, 8'h00);
        wreg(0, 5'h1c, 8'hff);
        rchk("unmapped", 0, 5'h1c, 8'h00);
        do_reset(1'b0);
        repeat (qmgp_pkg::DEBUG_HOLD_TICKS + 4) @(posedge i_ref_clk);
        rchk("cfg", 4, R_DAT, 8'h00);
        rchk("shared_pin", 2, R_DAT, 8'h01);
        chk("reset_pullup", {31'h0, rpu}, 32'h0);
        wreg(4, R_DAT, 8'h80);
        #1;
        chk("reset_pullup", {31'h0, rpu}, 32'h1);
        $display("test shared pin done");
        end_sim();
    end
    initial begin
        #(100 * 20000);
        num_errors++;
        end_sim();
    end
endmodule
